// ===== rtl/cca_chan.sv
// Purpose: One capture/compare channel: capture, match, toggle, PWM outputs.
// Assumes: Counter and pin are synchronous to CLK.
// Notes: Register storage lives in the top; this module holds the pin state.
module cca_chan
  import cca_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Configuration
  input wire cca_pkg::cca_chan_s cfg,
  input wire logic [1:0] pwm_bits,
  input wire logic [15:0] count,
  input wire logic overflow,
  // Pin
  input wire logic pin_in,
  output logic pin_out,
  // Events
  output logic capture,
  output logic match
);
  logic pin_prev_q;
  logic [10:0] mask;
  logic eq;
  logic rise;
  logic fall;

  // Compare width for the 8..11 bit PWM family.
  always_comb begin
    mask = 11'h0ff;
    case (pwm_bits)
      2'h1: mask = 11'h1ff;
      2'h2: mask = 11'h3ff;
      2'h3: mask = 11'h7ff;
      default: mask = 11'h0ff;
    endcase
  end

  assign rise = pin_in & ~pin_prev_q;
  assign fall = ~pin_in & pin_prev_q;
  // Equality is checked on the full word unless narrow PWM is running.
  assign eq = (cfg.mode[B_PWM] && !cfg.mode[B_WIDE] && !cfg.mode[B_TOG]) ?
              ((count[10:0] & mask) == (cfg.value[10:0] & mask)) :
              (count == cfg.value);
  assign match = cfg.mode[B_ECOM] & eq;
  assign capture = (cfg.mode[B_RISE] & rise) | (cfg.mode[B_FALL] & fall);

  // Previous pin level for edge detection.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_prev_q <= 1'b0;
    end else begin
      pin_prev_q <= pin_in;
    end
  end

  // Output pin: toggle, frequency output or PWM level.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out <= 1'b0;
    end else if (cfg.mode[B_TOG] && match) begin
      pin_out <= ~pin_out;
    end else if (cfg.mode[B_PWM] && !cfg.mode[B_TOG] && cfg.mode[B_ECOM]) begin
      // Low until the match, high after it; overflow restarts the period.
      if (match) begin
        pin_out <= 1'b1;
      end else if (overflow) begin
        pin_out <= 1'b0;
      end
    end
  end
endmodule : cca_chan

// ===== rtl/cca_pkg.sv
// Purpose: Shared constants and types for the capture/compare channel block.
// Assumes: APB slave with 32-bit data, one register per aligned word.
// Notes: Printed offsets are not multiples of four, so each is a word index.
package cca_pkg;
  localparam int NCH = 3;
  // Word indices of the registers; byte address is four times the index.
  localparam logic [7:0] IDX_MODE0 = 8'hda;
  localparam logic [7:0] IDX_MODE1 = 8'hdb;
  localparam logic [7:0] IDX_MODE2 = 8'hdc;
  localparam logic [7:0] IDX_VLO1 = 8'he9;
  localparam logic [7:0] IDX_VHI1 = 8'hea;
  localparam logic [7:0] IDX_VLO2 = 8'heb;
  localparam logic [7:0] IDX_VHI2 = 8'hec;
  localparam logic [7:0] IDX_VLO0 = 8'hfb;
  localparam logic [7:0] IDX_VHI0 = 8'hfc;
  localparam logic [7:0] IDX_CFG = 8'hf0;
  localparam logic [7:0] IDX_STAT = 8'hf1;
  localparam logic [7:0] IDX_MASK = 8'hf2;
  localparam logic [7:0] IDX_CNT = 8'hf3;
  // Mode register bit positions.
  localparam int B_WIDE = 7;
  localparam int B_ECOM = 6;
  localparam int B_RISE = 5;
  localparam int B_FALL = 4;
  localparam int B_MAT = 3;
  localparam int B_TOG = 2;
  localparam int B_PWM = 1;
  localparam int B_FIE = 0;
  // Config register bit positions and field.
  localparam int B_RELOAD_ACCESS_SELECT = 7;
  localparam int B_WATCHDOG_ENABLE = 6;
  localparam int B_CLSEL = 0;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [15:0] VAL_RST = 16'h0000;
  localparam logic [31:0] SLVERR_ZERO = 32'h0000_0000;
  // Index of the channel that doubles as the watchdog.
  localparam int WDT_CH = 5;
  typedef struct packed {
    logic [7:0] mode;
    logic [15:0] value;
    logic [15:0] reload;
  } cca_chan_s;
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } cca_apb_req_s;
endpackage : cca_pkg

// ===== rtl/cca_top.sv
// Purpose: Capture/compare channels of a counter array behind an APB slave.
// Assumes: 25 MHz clock; counter runs from CLK when enabled by software.
// Notes: Word index times four is the byte address of each register.
// Function
// - Width bit picks 16-bit or 8-11-bit compare in PWM mode, 16-bit otherwise; PWM pin still clears at the 8-11-bit overflow
// - Rise/fall enables select capture edges
// - Match enable sets flag on equality
// - Toggle inverts pin; with PWM, frequency output
// - PWM enable drives modulated output
// - Mask bit gates flag interrupt
// - Watchdog enable locks only a channel five mode; with three channels no mode is locked
// - Low/high bytes hold value halves
// - Reload select redirects byte accesses
// - Low byte write clears comparator enable
// - High byte write sets comparator enable
module cca_top
  import cca_pkg::*;
#(
  parameter int CHANNELS = cca_pkg::NCH
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Channel pins
  input wire logic [cca_pkg::NCH-1:0] CHANNEL_PIN_IN,
  output logic [cca_pkg::NCH-1:0] CHANNEL_PIN_OUT,
  output logic [cca_pkg::NCH-1:0] CHANNEL_PIN_OE,
  // Interrupt
  output logic IRQ
);
  cca_chan_s ch_q [NCH];
  logic [7:0] cfg_q;
  logic [NCH-1:0] flag_q;
  logic [NCH-1:0] mask_q;
  logic [15:0] count_q;
  logic [NCH-1:0] pin_out;
  logic [NCH-1:0] cap_ev;
  logic [NCH-1:0] mat_ev;
  logic [NCH-1:0] set_ev;
  logic [NCH-1:0] wr_mode;
  logic [NCH-1:0] wr_lo;
  logic [NCH-1:0] wr_hi;
  logic [NCH-1:0] oe_d;
  logic access;
  logic wr;
  logic mapped;
  logic [7:0] idx;
  logic overflow;
  logic [31:0] rdata;
  logic [1:0] pwm_bits;
  logic [15:0] top;
  logic counter_run;

  // Each access completes in its first access cycle; no wait states.
  assign access = PSEL & PENABLE;
  assign wr = access & PWRITE;
  assign idx = PADDR[9:2];
  assign pwm_bits = cfg_q[B_CLSEL +: 2];
  assign counter_run = cfg_q[B_CLSEL + 2];

  // Narrow PWM period ends at 2^n - 1; otherwise the counter wraps at 16 bits.
  always_comb begin
    case (pwm_bits)
      2'h1: top = 16'h01ff;
      2'h2: top = 16'h03ff;
      2'h3: top = 16'h07ff;
      default: top = 16'h00ff;
    endcase
  end
  assign overflow = counter_run & (((count_q & top) == top) | (count_q == 16'hffff));

  // Shared array counter, kept small here since only its value is needed.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      count_q <= VAL_RST;
    end else if (counter_run) begin
      count_q <= count_q + 16'h0001;
    end
  end

  // Configuration: reload select, watchdog enable, width and run bits.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cfg_q <= MODE_RST;
    end else if (wr && idx == IDX_CFG) begin
      cfg_q <= PWDATA[7:0];
    end
  end

  // Per-channel decode, channel logic and register storage.
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    localparam logic [7:0] IM = (i == 0) ? IDX_MODE0 : (i == 1) ? IDX_MODE1 : IDX_MODE2;
    localparam logic [7:0] IL = (i == 0) ? IDX_VLO0 : (i == 1) ? IDX_VLO1 : IDX_VLO2;
    localparam logic [7:0] IH = (i == 0) ? IDX_VHI0 : (i == 1) ? IDX_VHI1 : IDX_VHI2;
    // Only a channel numbered five is locked; with three channels none is.
    assign wr_mode[i] = wr && idx == IM && !(i == WDT_CH && cfg_q[B_WATCHDOG_ENABLE]);
    assign wr_lo[i] = wr && idx == IL;
    assign wr_hi[i] = wr && idx == IH;
    assign set_ev[i] = cap_ev[i] | (mat_ev[i] & ch_q[i].mode[B_MAT]);
    assign oe_d[i] = ch_q[i].mode[B_TOG] | ch_q[i].mode[B_PWM];

    cca_chan u_chan (
      .clk(CLK),
      .rst_n(RST_N),
      .cfg(ch_q[i]),
      .pwm_bits(ch_q[i].mode[B_WIDE] ? 2'h0 : pwm_bits),
      .count(count_q),
      .overflow(overflow),
      .pin_in(CHANNEL_PIN_IN[i]),
      .pin_out(pin_out[i]),
      .capture(cap_ev[i]),
      .match(mat_ev[i])
    );

    // Mode register; byte writes to the value force the comparator bit.
    always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
        ch_q[i].mode <= MODE_RST;
      end else if (wr_mode[i]) begin
        ch_q[i].mode <= PWDATA[7:0];
      end else if (wr_lo[i] && !cfg_q[B_RELOAD_ACCESS_SELECT]) begin
        ch_q[i].mode[B_ECOM] <= 1'b0;
      end else if (wr_hi[i] && !cfg_q[B_RELOAD_ACCESS_SELECT]) begin
        ch_q[i].mode[B_ECOM] <= 1'b1;
      end
    end

    // Capture/compare value: software bytes or counter snapshot on an edge.
    always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
        ch_q[i].value <= VAL_RST;
      end else if (cap_ev[i]) begin
        ch_q[i].value <= count_q;
      end else if (wr_lo[i] && !cfg_q[B_RELOAD_ACCESS_SELECT]) begin
        ch_q[i].value[7:0] <= PWDATA[7:0];
      end else if (wr_hi[i] && !cfg_q[B_RELOAD_ACCESS_SELECT]) begin
        ch_q[i].value[15:8] <= PWDATA[7:0];
      end else if (overflow && ch_q[i].mode[B_PWM] && !ch_q[i].mode[B_WIDE] &&
                   pwm_bits != 2'h0) begin
        // Narrow PWM of 9 to 11 bits takes the new duty only at the period boundary.
        ch_q[i].value <= ch_q[i].reload;
      end
    end

    // Auto-reload value reached through the value addresses.
    always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
        ch_q[i].reload <= VAL_RST;
      end else if (wr_lo[i] && cfg_q[B_RELOAD_ACCESS_SELECT]) begin
        ch_q[i].reload[7:0] <= PWDATA[7:0];
      end else if (wr_hi[i] && cfg_q[B_RELOAD_ACCESS_SELECT]) begin
        ch_q[i].reload[15:8] <= PWDATA[7:0];
      end
    end

    // Sticky flag: hardware set beats a write-one clear in the same cycle.
    always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
        flag_q[i] <= 1'b0;
      end else if (set_ev[i]) begin
        flag_q[i] <= 1'b1;
      end else if (wr && idx == IDX_STAT && PWDATA[i]) begin
        flag_q[i] <= 1'b0;
      end
    end
  end

  // Interrupt mask mirrors each channel's flag interrupt bit.
  always_comb begin
    for (int k = 0; k < NCH; k++) begin
      mask_q[k] = ch_q[k].mode[B_FIE];
    end
  end

  // Read multiplexer.
  always_comb begin
    rdata = SLVERR_ZERO;
    mapped = 1'b1;
    case (idx)
      IDX_MODE0: rdata[7:0] = ch_q[0].mode;
      IDX_MODE1: rdata[7:0] = ch_q[1].mode;
      IDX_MODE2: rdata[7:0] = ch_q[2].mode;
      IDX_VLO0: rdata[7:0] = cfg_q[B_RELOAD_ACCESS_SELECT] ? ch_q[0].reload[7:0] : ch_q[0].value[7:0];
      IDX_VHI0: rdata[7:0] = cfg_q[B_RELOAD_ACCESS_SELECT] ? ch_q[0].reload[15:8] : ch_q[0].value[15:8];
      IDX_VLO1: rdata[7:0] = cfg_q[B_RELOAD_ACCESS_SELECT] ? ch_q[1].reload[7:0] : ch_q[1].value[7:0];
      IDX_VHI1: rdata[7:0] = cfg_q[B_RELOAD_ACCESS_SELECT] ? ch_q[1].reload[15:8] : ch_q[1].value[15:8];
      IDX_VLO2: rdata[7:0] = cfg_q[B_RELOAD_ACCESS_SELECT] ? ch_q[2].reload[7:0] : ch_q[2].value[7:0];
      IDX_VHI2: rdata[7:0] = cfg_q[B_RELOAD_ACCESS_SELECT] ? ch_q[2].reload[15:8] : ch_q[2].value[15:8];
      IDX_CFG: rdata[7:0] = cfg_q;
      IDX_STAT: rdata[NCH-1:0] = flag_q;
      IDX_MASK: rdata[NCH-1:0] = mask_q;
      IDX_CNT: rdata[15:0] = count_q;
      default: mapped = 1'b0;
    endcase
    if (PADDR[31:10] != 22'h0 || PADDR[1:0] != 2'h0) begin
      mapped = 1'b0;
    end
  end

  // Registered APB answer: no wait states, so PREADY is high in the first access cycle.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      PREADY <= 1'b0;
      PRDATA <= SLVERR_ZERO;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL & ~PENABLE;
      PRDATA <= (PSEL & ~PENABLE & ~PWRITE & mapped) ? rdata : SLVERR_ZERO;
      PSLVERR <= PSEL & ~PENABLE & ~mapped;
    end
  end

  // Pins and interrupt come straight from flip-flops.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      CHANNEL_PIN_OUT <= '0;
      CHANNEL_PIN_OE <= '0;
      IRQ <= 1'b0;
    end else begin
      CHANNEL_PIN_OUT <= pin_out;
      CHANNEL_PIN_OE <= oe_d;
      IRQ <= |(flag_q & mask_q);
    end
  end
endmodule : cca_top

// ===== sim/cca_pin_model.sv
// Purpose: Outside circuitry on each channel pin.
// Assumes: The bench sets the level the outside drives.
// Notes: The outside drives through a resistor, so the block wins when enabled.
module cca_pin_model
  import cca_pkg::*;
(
  // From the bench
  input wire logic [cca_pkg::NCH-1:0] ext,
  // From and to the block
  input wire logic [cca_pkg::NCH-1:0] pin_out,
  input wire logic [cca_pkg::NCH-1:0] pin_oe,
  output logic [cca_pkg::NCH-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Wire level seen by every party.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule : cca_pin_model

// ===== sim/cca_top_monitor.sv
// Purpose: Port-level checks of the capture/compare block.
// Assumes: One clock domain, reset active low.
// Notes: Flag and mode effects trail a finished write by a few edges.
module cca_top_monitor
  import cca_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Bus
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Pins and interrupt
  input wire logic [cca_pkg::NCH-1:0] CHANNEL_PIN_OUT,
  input wire logic [cca_pkg::NCH-1:0] CHANNEL_PIN_OE,
  input wire logic IRQ
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  logic wr_done;
  // A write completes at the edge where ready is seen.
  assign wr_done = PSEL & PWRITE & PREADY;
  property p_rdy_pulse;
    PREADY |=> !PREADY;
  endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready held");
  property p_rdy_bus;
    PREADY |-> PSEL && PENABLE;
  endproperty
  a_rdy_bus: assert property (p_rdy_bus) else $error("ready outside access");
  property p_rdy_time;
    $rose(PENABLE) && PSEL |-> ##[0:2] PREADY;
  endproperty
  a_rdy_time: assert property (p_rdy_time) else $error("ready late");
  property p_err_rdy;
    PSLVERR |-> PREADY;
  endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("error without ready");
  property p_rd_zero;
    !PREADY |-> PRDATA == 32'h0000_0000;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read data idle");
  property p_irq_fall;
    $fell(IRQ) |-> $past(wr_done, 1) || $past(wr_done, 2) || $past(wr_done, 3);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("request dropped alone");
  property p_oe_cfg;
    $changed(CHANNEL_PIN_OE) |-> $past(wr_done, 1) || $past(wr_done, 2) || $past(wr_done, 3);
  endproperty
  a_oe_cfg: assert property (p_oe_cfg) else $error("enable moved alone");
  property p_pin_hold;
    !CHANNEL_PIN_OE[0] && $past(CHANNEL_PIN_OE[0]) == 1'b0 |-> $stable(CHANNEL_PIN_OUT[0]);
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("idle pin moved");
  // Main scenarios reached.
  c_irq: cover property ($rose(IRQ));
  c_err: cover property (PSLVERR);
  c_oe: cover property ($rose(CHANNEL_PIN_OE[2]));
endmodule : cca_top_monitor

bind cca_top cca_top_monitor cca_top_monitor_inst (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .CHANNEL_PIN_OUT(CHANNEL_PIN_OUT), .CHANNEL_PIN_OE(CHANNEL_PIN_OE), .IRQ(IRQ));

// ===== sim/tb_top.sv
// Purpose: Self-checking bench for the capture/compare block.
// Assumes: APB master here; register model kept in integers.
// Notes: Long PWM periods are sampled, not run out.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cca_pkg::*;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata;
  logic pready, pslverr, irq;
  logic [NCH-1:0] ext = 0, pin_in, pin_out, pin_oe;
  int n_mismatch = 0, cmp_count = 0;
  logic [7:0] mi[3] = '{IDX_MODE0, IDX_MODE1, IDX_MODE2};
  logic [7:0] lo[3] = '{IDX_VLO0, IDX_VLO1, IDX_VLO2};
  logic [7:0] hi[3] = '{IDX_VHI0, IDX_VHI1, IDX_VHI2};
  int m_mode[3], m_val[3], m_rel[3], m_ars;
  always #20 clk = ~clk;
  cca_top cca_top_inst (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .CHANNEL_PIN_IN(pin_in), .CHANNEL_PIN_OUT(pin_out),
    .CHANNEL_PIN_OE(pin_oe), .IRQ(irq));
  cca_pin_model cca_pin_model_inst (.ext(ext), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_in(pin_in));
  task automatic results();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One transfer; the request holds until ready is sampled high.
  task automatic apb(input logic w, input logic [7:0] ix, input logic [31:0] d,
                     output logic [31:0] r, output logic er);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {22'h0, ix, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      n_mismatch++;
      results();
    end
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Write, then mirror its effect in the model.
  task automatic wr(input logic [7:0] ix, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, ix, {24'h0, d}, r, e);
    if (ix == IDX_CFG) m_ars = d[B_RELOAD_ACCESS_SELECT];
    for (int i = 0; i < 3; i++) begin
      if (ix == mi[i]) m_mode[i] = d;
      if (ix == lo[i] && m_ars != 0) m_rel[i][7:0] = d;
      if (ix == hi[i] && m_ars != 0) m_rel[i][15:8] = d;
      if (ix == lo[i] && m_ars == 0) m_val[i][7:0] = d;
      if (ix == lo[i] && m_ars == 0) m_mode[i][B_ECOM] = 1'b0;
      if (ix == hi[i] && m_ars == 0) m_val[i][15:8] = d;
      if (ix == hi[i] && m_ars == 0) m_mode[i][B_ECOM] = 1'b1;
    end
  endtask : wr
  function automatic logic [31:0] exp_of(input logic [7:0] ix);
    exp_of = 0;
    for (int i = 0; i < 3; i++) begin
      if (ix == mi[i]) exp_of = m_mode[i];
      if (ix == lo[i]) exp_of = m_ars != 0 ? m_rel[i][7:0] : m_val[i][7:0];
      if (ix == hi[i]) exp_of = m_ars != 0 ? m_rel[i][15:8] : m_val[i][15:8];
    end
  endfunction : exp_of
  task automatic rd(input logic [7:0] ix, input logic [31:0] e, input logic ee);
    logic [31:0] r;
    logic er;
    apb(1'b0, ix, 32'h0, r, er);
    chk("read data", e, r);
    chk("slave error", {31'h0, ee}, {31'h0, er});
  endtask : rd
  initial begin
    logic [31:0] r, d;
    logic e;
    int n;
    void'($urandom(32'hbdfa6699));
    m_ars = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values, then byte writes that also steer the comparator enable.
    foreach (mi[i]) begin
      rd(mi[i], exp_of(mi[i]), 1'b0);
      rd(lo[i], exp_of(lo[i]), 1'b0);
      rd(hi[i], exp_of(hi[i]), 1'b0);
      d = $urandom;
      wr(hi[i], d[15:8]);
      rd(mi[i], exp_of(mi[i]), 1'b0);
      wr(lo[i], d[7:0]);
      rd(mi[i], exp_of(mi[i]), 1'b0);
      rd(hi[i], exp_of(hi[i]), 1'b0);
      rd(lo[i], exp_of(lo[i]), 1'b0);
    end
    // Reload select sends byte accesses to the reload value.
    d = $urandom;
    wr(IDX_CFG, 8'h81);
    wr(lo[0], d[7:0]);
    wr(hi[0], d[15:8]);
    rd(lo[0], exp_of(lo[0]), 1'b0);
    rd(mi[0], exp_of(mi[0]), 1'b0);
    wr(IDX_CFG, 8'h00);
    rd(hi[0], exp_of(hi[0]), 1'b0);
    rd(8'h00, 32'h0, 1'b1);
    // Every edge selection, with the flag cleared by writing one.
    wr(IDX_CFG, 8'h04);
    for (int m = 1; m < 4; m++) begin
      wr(mi[0], 8'(m * 16 + 1));
      ext[0] <= 1'b1;
      repeat (4) @(posedge clk);
      rd(IDX_STAT, 32'(m / 2), 1'b0);
      chk("irq", 32'(m / 2), {31'h0, irq});
      wr(IDX_STAT, 8'h01);
      ext[0] <= 1'b0;
      repeat (4) @(posedge clk);
      rd(IDX_STAT, 32'(m % 2), 1'b0);
      wr(IDX_STAT, 8'h01);
    end
    // Mask clear: flag sets, no request.
    wr(mi[0], 8'h20);
    ext[0] <= 1'b1;
    repeat (4) @(posedge clk);
    rd(IDX_STAT, 32'h1, 1'b0);
    chk("irq", 32'h0, {31'h0, irq});
    wr(IDX_STAT, 8'h01);
    // Match placed ahead of the running counter.
    apb(1'b0, IDX_CNT, 32'h0, r, e);
    d = r + 32'h400;
    wr(lo[1], d[7:0]);
    wr(hi[1], d[15:8]);
    wr(mi[1], 8'h48);
    n = 0;
    r = 0;
    while (r[1] !== 1'b1 && n < 600) begin
      apb(1'b0, IDX_STAT, 32'h0, r, e);
      n++;
    end
    chk("match flag", 32'h2, r);
    // Toggle and PWM take the pin; narrow PWM must move it.
    wr(mi[2], 8'h04);
    repeat (3) @(posedge clk);
    chk("oe toggle", 32'h1, {31'h0, pin_oe[2]});
    wr(lo[2], 8'h80);
    wr(mi[2], 8'h42);
    n = 0;
    for (int k = 0; k < 600; k++) begin
      @(posedge clk);
      n += pin_out[2];
    end
    chk("pwm high share", 32'h1, 32'(n > 100 && n < 500));
    wr(mi[2], 8'hc2);
    repeat (3) @(posedge clk);
    chk("oe wide", 32'h1, {31'h0, pin_oe[2]});
    wr(mi[2], 8'h00);
    repeat (3) @(posedge clk);
    chk("oe off", 32'h0, {31'h0, pin_oe[2]});
    results();
  end
endmodule : tb_top
